// file: rtl/mode_switch_interrupt_exec.v
// Contract
// - rotate byte one digit right through acc nibble
// - rotate byte one digit left through acc nibble
// - bit test: zero flag is inverse of bit
// - invert, clear or set one selected bit
// - carry repeat stops on carry clear or count zero
// - no-carry repeat stops when carry set
// - mode flag one native, zero emulation
// - reset and external interrupts return native
// - enter emulation: push, clear mode, vector
// - emulated registers map onto native bytes
// - emulation uses base pointer as stack
// - emulation leaves native-only registers alone
// - emulation fetch code segment, data segment zero
// - leave emulation: pop, mode one, native
// - call native: push mode zero, set one, vector
// - return restoring mode zero re-enters emulation
// - escape only forms address and starts read
// - escape read data ignored by device
// - software interrupt sources take vectors
// - vector table spans 000h to 3ffh
// - low word to pc, high word to segment
// - entry pushes at sp-2,-4,-6, sp minus six
`timescale 1ns/100ps
`include "mode_exec_defines.vh"
module mode_switch_interrupt_exec (
   input wire clk_sys,
   input wire rst_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   output reg mode_select_flag,
   output reg esc_read,
   output reg [19:0] esc_addr
);
   // ************************************************************
   // architectural state
   // ************************************************************
   reg [15:0] processor_status_word; // flags, mode in top bit
   reg [15:0] acc; // accumulator high and low bytes
   reg [15:0] count_register; // repeat count
   reg [15:0] code_segment_register; // code segment
   reg [15:0] pc; // program counter
   reg [15:0] native_stack_pointer; // native stack
   reg [15:0] base_pointer_register; // emulation stack
   reg [15:0] data_segment_zero; // emulation data segment
   reg [15:0] ea; // effective address for escape
   reg [15:0] opnd; // byte operand and bit index / vector
   reg [15:0] result; // operand written back
   reg [19:0] last_push; // address of last pushed word
   reg [7:0] vec_num; // last vector taken
   reg [15:0] frame [0:2]; // last stacked frame: psw, ps, pc
   reg [15:0] vec_lo; // vector offset word supplied by software
   reg [15:0] vec_hi; // vector segment word supplied by software
   reg rep_active; // repeat prefix running
   reg rep_kind; // 1: while carry, 0: while no carry
   reg [3:0] last_cmd; // last command executed
   // ************************************************************
   // bus pipeline
   // ************************************************************
   reg dp_wr; // data phase write pending
   reg [7:0] dp_addr; // latched address
   wire ap_valid;
   assign ap_valid = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1; // zero wait states
   assign hresp = 1'b0; // always okay
   // ************************************************************
   // helper functions
   // ************************************************************
   // physical address from segment and offset
   function [19:0] phys;
      input [15:0] seg;
      input [15:0] off;
      begin
         phys = {seg, 4'h0} + {4'h0, off};
      end
   endfunction
   // byte-swap of a vector word
   function [15:0] swap;
      input [15:0] w;
      begin
         swap = {w[7:0], w[15:8]};
      end
   endfunction
   // stack pointer in use for the current mode
   wire [15:0] stk_ptr;
   assign stk_ptr = mode_select_flag ? native_stack_pointer :
      base_pointer_register;
   // selected bit inside the byte operand
   wire [3:0] bit_sel;
   assign bit_sel = opnd[11:8];
   // one-hot mask of the selected bit
   wire [15:0] bit_mask;
   assign bit_mask = 16'h0001 << bit_sel;
   // a control write in its data phase starts a command
   wire cmd_go;
   assign cmd_go = dp_wr & (dp_addr == `ADDR_CTRL);
   wire [3:0] cmd;
   assign cmd = hwdata[3:0];
   wire [15:0] sp_new;
   assign sp_new = native_stack_pointer - `FRAME_BYTES;
   // ************************************************************
   // bus address latch
   // ************************************************************
   // hold address phase for the following data phase
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         dp_wr <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_wr <= ap_valid & hwrite;
         if (ap_valid) begin
            dp_addr <= {haddr[7:2], 2'b00};
         end
      end
   end
   // ************************************************************
   // execution and register writes
   // ************************************************************
   // one command per control write; repeats step per cycle
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         processor_status_word <= `PSW_RESET;
         mode_select_flag <= 1'b1;
         acc <= 16'h0000;
         count_register <= 16'h0000;
         code_segment_register <= 16'h0000;
         pc <= 16'h0000;
         native_stack_pointer <= 16'h0000;
         base_pointer_register <= 16'h0000;
         data_segment_zero <= 16'h0000;
         ea <= 16'h0000;
         opnd <= 16'h0000;
         result <= 16'h0000;
         last_push <= 20'h00000;
         vec_num <= 8'h00;
         frame[0] <= 16'h0000;
         frame[1] <= 16'h0000;
         frame[2] <= 16'h0000;
         vec_lo <= 16'h0000;
         vec_hi <= 16'h0000;
         rep_active <= 1'b0;
         rep_kind <= 1'b0;
         last_cmd <= 4'h0;
         esc_read <= 1'b0;
         esc_addr <= 20'h00000;
      end else begin
         esc_read <= 1'b0;
         // repeat stepping: carry repeat counts down, stop on carry clear or count zero
         if (rep_active) begin
            if (rep_kind) begin
               if (!processor_status_word[`PSW_CY] ||
                   count_register == 16'h0000) begin
                  rep_active <= 1'b0;
               end else begin
                  count_register <= count_register - 16'h0001;
               end
            end else if (processor_status_word[`PSW_CY]) begin
               rep_active <= 1'b0;
            end
         end
         if (dp_wr) begin
            case (dp_addr)
               `ADDR_OPND: opnd <= hwdata[15:0];
               `ADDR_ACC: begin
                  // emulation may only touch the low byte
                  if (mode_select_flag) begin
                     acc <= hwdata[15:0];
                  end else begin
                     acc[7:0] <= hwdata[7:0];
                  end
               end
               `ADDR_CNT: count_register <= hwdata[15:0];
               `ADDR_PSW: processor_status_word[14:0] <= hwdata[14:0];
               `ADDR_SEG: begin
                  if (mode_select_flag) begin
                     code_segment_register <= hwdata[15:0];
                  end
               end
               `ADDR_PC: pc <= hwdata[15:0];
               `ADDR_STK: begin
                  if (mode_select_flag) begin
                     native_stack_pointer <= hwdata[15:0];
                  end
               end
               `ADDR_BP: base_pointer_register <= hwdata[15:0];
               `ADDR_DS0: begin
                  if (mode_select_flag) begin
                     data_segment_zero <= hwdata[15:0];
                  end
               end
               `ADDR_IDX: ea <= hwdata[15:0];
               `ADDR_VEC: begin
                  vec_lo <= hwdata[15:0];
                  vec_hi <= hwdata[31:16];
               end
               default: begin
               end
            endcase
         end
         if (cmd_go) begin
            last_cmd <= cmd;
            case (cmd)
               `CMD_ROT_R: begin
                  result <= {8'h00, acc[3:0], opnd[7:4]};
                  acc[3:0] <= opnd[3:0];
               end
               `CMD_ROT_L: begin
                  result <= {8'h00, opnd[3:0], acc[3:0]};
                  acc[3:0] <= opnd[7:4];
               end
               `CMD_BTEST: begin
                  processor_status_word[`PSW_Z] <=
                     ~|(opnd[7:0] & bit_mask[7:0]);
               end
               `CMD_BINV: result <= {8'h00, opnd[7:0] ^ bit_mask[7:0]};
               `CMD_BCLR: result <= {8'h00, opnd[7:0] & ~bit_mask[7:0]};
               `CMD_BSET: result <= {8'h00, opnd[7:0] | bit_mask[7:0]};
               `CMD_REP_C: begin
                  rep_active <= 1'b1;
                  rep_kind <= 1'b1;
               end
               `CMD_REP_NC: begin
                  rep_active <= 1'b1;
                  rep_kind <= 1'b0;
               end
               `CMD_ENTER_EMULATION_BREAK, `CMD_SWINT, `CMD_EXTINT, `CMD_CALL_NATIVE_FROM_EMULATION: begin
                  // interrupt entry frame, vector from table
                  frame[0] <= processor_status_word;
                  frame[1] <= code_segment_register;
                  frame[2] <= pc;
                  if (cmd == `CMD_CALL_NATIVE_FROM_EMULATION) begin
                     // saved mode of zero, stack is base pointer
                     frame[0][`PSW_MD] <= 1'b0;
                     base_pointer_register <= base_pointer_register -
                        `FRAME_BYTES;
                     last_push <= phys(code_segment_register,
                        base_pointer_register - `FRAME_BYTES);
                  end else begin
                     native_stack_pointer <= sp_new;
                     last_push <= phys(code_segment_register, sp_new);
                  end
                  vec_num <= opnd[7:0];
                  pc <= swap(vec_lo);
                  code_segment_register <= swap(vec_hi);
                  processor_status_word[`PSW_IE] <= 1'b0;
                  processor_status_word[`PSW_BRK] <= 1'b0;
                  // break for emulation clears mode, others set it
                  if (cmd == `CMD_ENTER_EMULATION_BREAK) begin
                     processor_status_word[`PSW_MD] <= 1'b0;
                     mode_select_flag <= 1'b0;
                  end else begin
                     processor_status_word[`PSW_MD] <= 1'b1;
                     mode_select_flag <= 1'b1;
                  end
               end
               `CMD_LEAVE_EMULATION_RETURN, `CMD_IRET: begin
                  // pop frame; return from emulation forces native
                  pc <= frame[2];
                  code_segment_register <= frame[1];
                  native_stack_pointer <= native_stack_pointer +
                     `FRAME_BYTES;
                  if (cmd == `CMD_LEAVE_EMULATION_RETURN) begin
                     processor_status_word <= frame[0] | `PSW_RESET;
                     mode_select_flag <= 1'b1;
                  end else begin
                     processor_status_word <= frame[0];
                     mode_select_flag <= frame[0][`PSW_MD];
                  end
               end
               `CMD_ESC: begin
                  // address only; returned data never latched
                  esc_read <= 1'b1;
                  esc_addr <= phys(data_segment_zero, ea);
               end
               default: begin
               end
            endcase
         end
      end
   end
   // ************************************************************
   // read mux
   // ************************************************************
   // registered read data for the data phase
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
      end else if (ap_valid & ~hwrite) begin
         case ({haddr[7:2], 2'b00})
            `ADDR_CTRL: hrdata <= {28'h0000000, last_cmd};
            `ADDR_OPND: hrdata <= {16'h0000, opnd};
            `ADDR_ACC: hrdata <= {16'h0000, acc};
            `ADDR_CNT: hrdata <= {16'h0000, count_register};
            `ADDR_PSW: hrdata <= {16'h0000, processor_status_word};
            `ADDR_SEG: hrdata <= {16'h0000, code_segment_register};
            `ADDR_PC: hrdata <= {16'h0000, pc};
            `ADDR_STK: hrdata <= {16'h0000, stk_ptr};
            `ADDR_BP: hrdata <= {16'h0000, base_pointer_register};
            `ADDR_RES: hrdata <= {16'h0000, result};
            `ADDR_STAT: hrdata <= {22'h000000, rep_active,
               mode_select_flag, vec_num};
            `ADDR_VEC: hrdata <= {vec_hi, vec_lo};
            `ADDR_BUSA: hrdata <= {12'h000, last_push};
            `ADDR_DS0: hrdata <= {16'h0000, data_segment_zero};
            `ADDR_IDX: hrdata <= {16'h0000, ea};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end
endmodule

// file: shared/mode_exec_defines.vh
`ifndef MODE_EXEC_DEFINES_VH
`define MODE_EXEC_DEFINES_VH
// ************************************************************
// register map, byte addresses
// ************************************************************
`define ADDR_CTRL 8'h00
`define ADDR_OPND 8'h04
`define ADDR_ACC 8'h08
`define ADDR_CNT 8'h0c
`define ADDR_PSW 8'h10
`define ADDR_SEG 8'h14
`define ADDR_PC 8'h18
`define ADDR_STK 8'h1c
`define ADDR_BP 8'h20
`define ADDR_RES 8'h24
`define ADDR_STAT 8'h28
`define ADDR_VEC 8'h2c
`define ADDR_BUSA 8'h30
`define ADDR_DS0 8'h34
`define ADDR_IDX 8'h38
// ************************************************************
// command codes written to ctrl[3:0]
// ************************************************************
`define CMD_ROT_R 4'h1
`define CMD_ROT_L 4'h2
`define CMD_BTEST 4'h3
`define CMD_BINV 4'h4
`define CMD_BCLR 4'h5
`define CMD_BSET 4'h6
`define CMD_REP_C 4'h7
`define CMD_REP_NC 4'h8
`define CMD_ENTER_EMULATION_BREAK 4'h9
`define CMD_LEAVE_EMULATION_RETURN 4'ha
`define CMD_CALL_NATIVE_FROM_EMULATION 4'hb
`define CMD_IRET 4'hc
`define CMD_ESC 4'hd
`define CMD_SWINT 4'he
`define CMD_EXTINT 4'hf
// ************************************************************
// status word field positions
// ************************************************************
`define PSW_CY 0
`define PSW_P 2
`define PSW_AC 4
`define PSW_Z 6
`define PSW_S 7
`define PSW_BRK 8
`define PSW_IE 9
`define PSW_MD 15
`define PSW_RESET 16'h8000
// ************************************************************
// vector table and stack frame
// ************************************************************
`define VEC_SHIFT 2
`define FRAME_BYTES 16'h0006
`endif

// file: tb/copro_mem_model.sv
`timescale 1ns/100ps
// ************************************************************
// vector memory and coprocessor on the bus
// ************************************************************
module copro_mem_model (
   input wire clk_sys,
   input wire rst_n,
   input wire esc_read,
   input wire [19:0] esc_addr
);
   reg [7:0] mem [0:1023]; // vector table, four bytes a vector
   integer esc_cnt; // escape reads seen
   reg [19:0] esc_last; // address the coprocessor took
   integer i;
   // fill the table with a byte pattern
   initial begin
      for (i = 0; i < 1024; i = i + 1) begin
         mem[i] = i[7:0] ^ 8'h5a;
      end
      esc_cnt = 0;
      esc_last = 20'h0;
   end
   // coprocessor takes the address; the cpu ignores the data
   always @(posedge clk_sys) begin
      if (esc_read) begin
         esc_cnt <= esc_cnt + 1;
         esc_last <= esc_addr;
      end
   end
   // vector entry as software reads it, low byte first
   function [31:0] vec_word(input [7:0] n);
      vec_word = {mem[{n, 2'd3}], mem[{n, 2'd2}],
         mem[{n, 2'd1}], mem[{n, 2'd0}]};
   endfunction
endmodule

// file: tb/mode_exec_chk_assertions.sv
`timescale 1ns/100ps
`include "mode_exec_defines.vh"
// ************************************************************
// mode and escape checks at the block's ports
// ************************************************************
module mode_exec_chk (
   input wire clk_sys,
   input wire rst_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire mode_select_flag,
   input wire esc_read,
   input wire [19:0] esc_addr
);
   reg aw; // a write data phase is under way
   reg [7:0] aa; // its byte address
   wire cw = aw && aa == `ADDR_CTRL; // command write in data phase
   wire [3:0] c = hwdata[3:0]; // command code on the bus
   wire ce = cw && c == `CMD_ESC; // escape command
   // follow the address phase into the data phase
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         aw <= 1'b0;
         aa <= 8'h00;
      end else if (hready) begin
         aw <= hsel && htrans[1] && hwrite;
         aa <= haddr[7:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_reset_native: assert property (
      disable iff (1'b0) !rst_n |=> mode_select_flag)
      else $error("mode not native after reset");
   chk_mode_cause: assert property (
      $changed(mode_select_flag) && $past(rst_n) |-> $past(cw))
      else $error("mode changed with no command");
   chk_enter_emulation_break_mode: assert property (
      cw && c == `CMD_ENTER_EMULATION_BREAK && mode_select_flag |=> !mode_select_flag)
      else $error("enter emulation kept native mode");
   chk_leave_emulation_return_mode: assert property (
      cw && c == `CMD_LEAVE_EMULATION_RETURN && !mode_select_flag |=> mode_select_flag)
      else $error("leave emulation kept emulation");
   chk_call_native_from_emulation_mode: assert property (
      cw && c == `CMD_CALL_NATIVE_FROM_EMULATION && !mode_select_flag |=> mode_select_flag)
      else $error("call native kept emulation");
   chk_ext_native: assert property (
      cw && c == `CMD_EXTINT |=> mode_select_flag)
      else $error("external interrupt not native");
   chk_entry_mode: assert property (
      cw && c == `CMD_SWINT |=> mode_select_flag)
      else $error("interrupt entry did not set mode");
   chk_esc_pulse: assert property (
      ce |=> esc_read ##1 !esc_read)
      else $error("escape read not one pulse");
   chk_esc_cause: assert property (
      esc_read |-> $past(ce))
      else $error("escape read with no escape command");
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
`include "mode_exec_defines.vh"
module tb_top;
   reg clk_sys = 1'b0; // 200 MHz
   reg rst_n = 1'b0;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'b00;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, mode_select_flag, esc_read;
   wire [19:0] esc_addr;
   integer bad_count = 0;
   integer n_checks = 0;
   reg [31:0] rv; // last read data
   integer k;
   always #2.5 clk_sys = ~clk_sys;
   mode_switch_interrupt_exec dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .mode_select_flag(mode_select_flag), .esc_read(esc_read),
      .esc_addr(esc_addr));
   copro_mem_model mem_m (.clk_sys(clk_sys), .rst_n(rst_n),
      .esc_read(esc_read), .esc_addr(esc_addr));
   // ************************************************************
   // verdict, bus and compare helpers
   // ************************************************************
   task summarize;
      if (bad_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task ck(input [63:0] nm, input [31:0] e, input [31:0] g);
      n_checks = n_checks + 1;
      if (g !== e) begin
         $display("BAD %0s exp %h got %h", nm, e, g);
         bad_count = bad_count + 1;
      end
   endtask
   // wait, bounded, for ready at a rising edge
   task rdy;
      integer n;
      n = 0;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n = n + 1;
      end
      if (n >= 20) begin
         $display("BAD ready exp 1 got %b", hreadyout);
         bad_count = bad_count + 1;
         summarize;
      end
   endtask
   // one single word transfer; read data lands in rv
   task xf(input [7:0] a, input w, input [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy;
      htrans <= 2'b00;
      hwdata <= d;
      rdy;
      rv = hrdata;
      ck("resp", 32'h0, {31'h0, hresp});
   endtask
   task wr(input [7:0] a, input [31:0] d);
      xf(a, 1'b1, d);
   endtask
   task rc(input [7:0] a, input [63:0] nm, input [31:0] e);
      xf(a, 1'b0, 32'h0);
      ck(nm, e, rv);
   endtask
   task cmd(input [3:0] c);
      xf(`ADDR_CTRL, 1'b1, {28'h0, c});
   endtask
   // mode pin once the command edge has settled
   task md(input e);
      @(negedge clk_sys);
      ck("mode", {31'h0, e}, {31'h0, mode_select_flag});
      @(posedge clk_sys);
   endtask
   task vec(input [7:0] n);
      wr(`ADDR_VEC, mem_m.vec_word(n));
      wr(`ADDR_OPND, {24'h0, n});
   endtask
   task chkv(input [7:0] n);
      rc(`ADDR_PC, "pc", {16'h0, mem_m.mem[{n, 2'd0}], mem_m.mem[{n, 2'd1}]});
      rc(`ADDR_SEG, "seg", {16'h0, mem_m.mem[{n, 2'd2}],
         mem_m.mem[{n, 2'd3}]});
   endtask
   // poll until the repeat stops
   task idle;
      k = 0;
      rv = 32'h200;
      while (rv[9] !== 1'b0 && k < 20) begin
         xf(`ADDR_STAT, 1'b0, 32'h0);
         k = k + 1;
      end
      ck("rep", 32'h0, {31'h0, rv[9]});
      // a repeat that never stops ends the run
      if (rv[9] !== 1'b0) begin
         summarize;
      end
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task t_rot;
      wr(`ADDR_ACC, 32'h1273);
      wr(`ADDR_OPND, 32'h5a);
      cmd(`CMD_ROT_R);
      rc(`ADDR_RES, "res", 32'h35);
      rc(`ADDR_ACC, "acc", 32'h127a);
      wr(`ADDR_ACC, 32'h1273);
      cmd(`CMD_ROT_L);
      rc(`ADDR_RES, "res", 32'ha3);
      rc(`ADDR_ACC, "acc", 32'h1275);
   endtask
   task bop(input [3:0] c, input [11:0] o, input [7:0] e);
      wr(`ADDR_OPND, {20'h0, o});
      cmd(c);
      xf(`ADDR_RES, 1'b0, 32'h0);
      ck("bit", {24'h0, e}, {24'h0, rv[7:0]});
   endtask
   task t_bits;
      wr(`ADDR_OPND, 32'h05a);
      cmd(`CMD_BTEST);
      xf(`ADDR_PSW, 1'b0, 32'h0);
      ck("zero", 32'h1, {31'h0, rv[6]});
      wr(`ADDR_OPND, 32'h15a);
      cmd(`CMD_BTEST);
      xf(`ADDR_PSW, 1'b0, 32'h0);
      ck("zero", 32'h0, {31'h0, rv[6]});
      bop(`CMD_BINV, 12'h05a, 8'h5b);
      bop(`CMD_BCLR, 12'h15a, 8'h58);
      bop(`CMD_BSET, 12'h25a, 8'h5e);
   endtask
   task t_rep;
      wr(`ADDR_CNT, 32'h3);
      wr(`ADDR_PSW, 32'h1);
      cmd(`CMD_REP_C);
      idle;
      rc(`ADDR_CNT, "cnt", 32'h0);
      wr(`ADDR_CNT, 32'h5);
      wr(`ADDR_PSW, 32'h0);
      cmd(`CMD_REP_C);
      idle;
      rc(`ADDR_CNT, "cnt", 32'h5);
      cmd(`CMD_REP_NC);
      xf(`ADDR_STAT, 1'b0, 32'h0);
      ck("rep", 32'h1, {31'h0, rv[9]});
      wr(`ADDR_PSW, 32'h1);
      idle;
   endtask
   task t_mode;
      wr(`ADDR_STK, 32'h0100);
      wr(`ADDR_BP, 32'h0200);
      wr(`ADDR_DS0, 32'h3333);
      wr(`ADDR_ACC, 32'h4455);
      vec(8'h40);
      cmd(`CMD_ENTER_EMULATION_BREAK);
      md(1'b0);
      rc(`ADDR_STAT, "stat", 32'h40);
      rc(`ADDR_STK, "stk", 32'h0200);
      wr(`ADDR_SEG, 32'h9999);
      wr(`ADDR_STK, 32'h7777);
      wr(`ADDR_DS0, 32'h0);
      wr(`ADDR_ACC, 32'hff00);
      chkv(8'h40);
      rc(`ADDR_DS0, "ds0", 32'h3333);
      rc(`ADDR_ACC, "acc", 32'h4400);
      vec(8'h41);
      cmd(`CMD_CALL_NATIVE_FROM_EMULATION);
      md(1'b1);
      chkv(8'h41);
      rc(`ADDR_STK, "sp", 32'h00fa);
      rc(`ADDR_BP, "bp", 32'h01fa);
      cmd(`CMD_IRET);
      md(1'b0);
      cmd(`CMD_LEAVE_EMULATION_RETURN);
      md(1'b1);
   endtask
   task t_ext;
      vec(8'h42);
      cmd(`CMD_ENTER_EMULATION_BREAK);
      md(1'b0);
      cmd(`CMD_EXTINT);
      md(1'b1);
      cmd(`CMD_IRET);
      md(1'b0);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      md(1'b1);
      rc(`ADDR_PSW, "psw", 32'h8000);
   endtask
   task t_swint;
      wr(`ADDR_STK, 32'h0100);
      wr(`ADDR_PSW, 32'h0300);
      vec(8'h20);
      cmd(`CMD_SWINT);
      chkv(8'h20);
      rc(`ADDR_STK, "sp", 32'h00fa);
      rc(`ADDR_BUSA, "push", 32'h000fa);
      xf(`ADDR_PSW, 1'b0, 32'h0);
      ck("psw", 32'h8000, rv & 32'h8300);
   endtask
   task t_esc;
      wr(`ADDR_DS0, 32'h1234);
      wr(`ADDR_IDX, 32'h0010);
      wr(`ADDR_ACC, 32'h0055);
      k = mem_m.esc_cnt;
      cmd(`CMD_ESC);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      ck("esccnt", k + 1, mem_m.esc_cnt);
      ck("escadr", 32'h12350, {12'h0, mem_m.esc_last});
      @(posedge clk_sys);
      rc(`ADDR_ACC, "acc", 32'h0055);
   endtask
   // reset, then the scenarios in turn
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      rc(`ADDR_PSW, "psw", 32'h8000);
      t_rot;
      t_bits;
      t_rep;
      t_mode;
      t_ext;
      t_swint;
      t_esc;
      summarize;
   end
endmodule
bind mode_switch_interrupt_exec mode_exec_chk chk (.clk_sys(clk_sys),
   .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .mode_select_flag(mode_select_flag), .esc_read(esc_read),
   .esc_addr(esc_addr));
